// File: common/ccdv_pkg.sv
// constants shared by the vertical pattern and region timing logic
package ccdv_pkg;
   localparam int unsigned NUM_PAT     = 4;
   localparam int unsigned NUM_PHASE   = 4;
   localparam int unsigned NUM_PROG_BD = 4;
   localparam int unsigned NUM_REGION  = NUM_PROG_BD + 1;
   localparam int unsigned PIX_W       = 9;
   localparam int unsigned LINE_W      = 8;
   localparam int unsigned REP_W       = 3;
   localparam int unsigned PTR_W       = 3;
   localparam int unsigned SEL_W       = 2;
   localparam int unsigned REGION_W    = 3;
   localparam int unsigned DIV_W       = 8;
   // fixed first boundary, never programmable
   localparam logic [LINE_W-1:0]   FIXED_FIRST_BOUNDARY = 8'h00;
   localparam logic [LINE_W-1:0]   LINE_MAX   = 8'hFF;
   localparam logic [PIX_W-1:0]    PIX_MAX    = 9'h1FF;
   // pointer codes above the four direct selects
   localparam logic [PTR_W-1:0]    PTR_EVEN_ODD_01 = 3'h4;
   localparam logic [PTR_W-1:0]    PTR_EVEN_ODD_23 = 3'h5;
   // reset values
   localparam logic [PIX_W-1:0]    PIX_RST    = 9'h000;
   localparam logic [REP_W-1:0]    REP_RST    = 3'h0;
   localparam logic [LINE_W-1:0]   LINE_RST   = 8'h00;
   localparam logic [REGION_W-1:0] REGION_RST = 3'h0;
   localparam logic [NUM_PHASE-1:0] PHASE_RST = 4'h0;
   localparam logic [DIV_W-1:0]    DIV_RST    = 8'h00;
   // system clocks per vertical pixel counter step
   localparam int unsigned PIX_DIV_DEF = 5;
endpackage

// File: verilog/ccdv_vtiming.sv
// vertical transfer pattern generator with line-region sequencing
`timescale 1ns/10ps

// How it works
// - field is split into consecutive line regions, each with its own timing.
// - each region boundary is an 8-bit line number.
// - four programmable boundaries plus the fixed one give five regions.
// - first boundary is fixed at line zero, region zero starts the field.
// - four independent patterns, each configuring all four phase outputs.
// - each pattern has a 9-bit repetition length in pixel counts.
// - per phase start level, zero starts low, one starts high.
// - per phase first toggle position, 9 bits, compared with pixel counter.
// - per phase second toggle position, 9 bits, toggles level again.
// - chosen pattern repeats a programmed count and drives its region.
// - count one gives one pulse per line, zero holds the start level.
// - toggles are pixel positions in each repetition, starting from start level.
// - region pointer picks a 2-bit pattern select choosing the pattern.
// - region zero begins at the falling edge of field sync.
module ccdv_vtiming #(
   parameter int unsigned PIX_DIV = ccdv_pkg::PIX_DIV_DEF
) (
   input  wire logic                                                    clk_sys_i,
   input  wire logic                                                    reset_n_i,
   input  wire logic                                                    field_sync_i,
   input  wire logic                                                    line_sync_i,
   input  wire logic [ccdv_pkg::NUM_PAT*ccdv_pkg::PIX_W-1:0]            pattern_repeat_length_i,
   input  wire logic [ccdv_pkg::NUM_PAT*ccdv_pkg::NUM_PHASE-1:0]        phase_start_level_i,
   input  wire logic [ccdv_pkg::NUM_PAT*ccdv_pkg::NUM_PHASE*ccdv_pkg::PIX_W-1:0] phase_toggle_a_i,
   input  wire logic [ccdv_pkg::NUM_PAT*ccdv_pkg::NUM_PHASE*ccdv_pkg::PIX_W-1:0] phase_toggle_b_i,
   input  wire logic [ccdv_pkg::NUM_PAT*ccdv_pkg::REP_W-1:0]            pattern_repeat_count_i,
   input  wire logic [ccdv_pkg::NUM_PAT*ccdv_pkg::SEL_W-1:0]            pattern_select_i,
   input  wire logic [ccdv_pkg::NUM_REGION*ccdv_pkg::PTR_W-1:0]         region_pattern_pointer_i,
   input  wire logic [ccdv_pkg::NUM_PROG_BD*ccdv_pkg::LINE_W-1:0]       region_boundary_line_i,
   output logic      [ccdv_pkg::NUM_PHASE-1:0]                          vertical_phase_o,
   output logic      [ccdv_pkg::REGION_W-1:0]                           region_o,
   output logic      [ccdv_pkg::LINE_W-1:0]                             line_count_o
);
   import ccdv_pkg::*;

   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PIX_DIV - 1);

   logic [DIV_W-1:0]     div_cnt;
   logic [DIV_W-1:0]     next_div_cnt;
   logic                 pix_en;
   logic                 field_q;
   logic                 line_q;
   logic [PIX_W-1:0]     pix;
   logic [PIX_W-1:0]     next_pix;
   logic [REP_W-1:0]     rep;
   logic [REP_W-1:0]     next_rep;
   logic [LINE_W-1:0]    next_line;
   logic [REGION_W-1:0]  next_region;
   logic [NUM_PHASE-1:0] next_phase;
   logic                 field_start;
   logic                 line_start;
   logic [REGION_W-1:0]  act_region;
   logic [PTR_W-1:0]     cur_ptr;
   logic [SEL_W-1:0]     sel_idx;
   logic [SEL_W-1:0]     cur_pat;
   logic [PIX_W-1:0]     cur_len;
   logic [REP_W-1:0]     cur_count;
   logic                 pat_active;
   logic                 wrap;
   logic [NUM_PHASE-1:0] cur_start;
   logic [NUM_PHASE-1:0] cur_level;

   // pixel rate as an enable; divider free-runs so edges stay evenly spaced
   always_comb begin
      pix_en       = (div_cnt == DIV_LAST);
      next_div_cnt = pix_en ? DIV_RST : div_cnt + 8'h01;
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div_cnt <= DIV_RST;
         field_q <= 1'b1;
         line_q  <= 1'b1;
      end else begin
         div_cnt <= next_div_cnt;
         field_q <= field_sync_i;
         line_q  <= line_sync_i;
      end
   end

   assign field_start = field_q && !field_sync_i;
   assign line_start  = line_q && !line_sync_i;

   // highest region whose boundary is at or below the line count
   always_comb begin
      // region zero opens at the fixed first boundary
      act_region = REGION_RST;
      for (int i = 0; i < NUM_PROG_BD; i++) begin
         if (region_boundary_line_i[i*LINE_W +: LINE_W] <= line_count_o &&
             region_boundary_line_i[i*LINE_W +: LINE_W] >= FIXED_FIRST_BOUNDARY) begin
            act_region = REGION_W'(i + 1);
         end
      end
   end

   // pointer picks a select register, select picks the pattern
   always_comb begin
      cur_ptr = region_pattern_pointer_i[act_region*PTR_W +: PTR_W];
      unique case (cur_ptr)
         PTR_EVEN_ODD_01: sel_idx = {1'b0, line_count_o[0]};
         PTR_EVEN_ODD_23: sel_idx = {1'b1, line_count_o[0]};
         // unused pointer codes fall back to the first select register
         3'h6, 3'h7:      sel_idx = 2'h0;
         default:         sel_idx = cur_ptr[SEL_W-1:0];
      endcase
      cur_pat   = pattern_select_i[sel_idx*SEL_W +: SEL_W];
      // repetition length of the chosen pattern
      cur_len   = pattern_repeat_length_i[cur_pat*PIX_W +: PIX_W];
      cur_count = pattern_repeat_count_i[cur_pat*REP_W +: REP_W];
      pat_active = (rep < cur_count);
      wrap       = (cur_len != PIX_RST) && (pix == cur_len - 9'h001);
   end

   // per-phase settings of the chosen pattern
   generate
      for (genvar k = 0; k < NUM_PHASE; k++) begin : g_phase
         logic [PIX_W-1:0] tog_a;
         logic [PIX_W-1:0] tog_b;
         always_comb begin
            tog_a        = phase_toggle_a_i[(cur_pat*NUM_PHASE+k)*PIX_W +: PIX_W];
            tog_b        = phase_toggle_b_i[(cur_pat*NUM_PHASE+k)*PIX_W +: PIX_W];
            cur_start[k] = phase_start_level_i[cur_pat*NUM_PHASE+k];
            // first toggle, second toggle, from the start level
            cur_level[k] = cur_start[k] ^ (pix >= tog_a) ^ (pix >= tog_b);
         end
      end
   endgenerate

   // line, pixel and repetition sequencing
   always_comb begin
      next_line = line_count_o;
      next_pix  = pix;
      next_rep  = rep;
      if (field_start) begin
         // region zero restarts with the field
         next_line = FIXED_FIRST_BOUNDARY;
         next_pix  = PIX_RST;
         next_rep  = REP_RST;
      end else if (line_start) begin
         // saturates so a long field stays in the last region
         if (line_count_o != LINE_MAX) begin
            next_line = line_count_o + 8'h01;
         end
         next_pix = PIX_RST;
         next_rep = REP_RST;
      end else if (pix_en && pat_active) begin
         if (wrap) begin
            next_pix = PIX_RST;
            // count repetitions up to the programmed number
            next_rep = rep + 3'h1;
         end else if (pix != PIX_MAX) begin
            next_pix = pix + 9'h001;
         end
      end
      // each region drives its own pattern
      next_region = act_region;
      // exhausted or zero count holds the start level
      next_phase  = pat_active ? cur_level : cur_start;
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pix              <= PIX_RST;
         rep              <= REP_RST;
         line_count_o     <= LINE_RST;
         region_o         <= REGION_RST;
         vertical_phase_o <= PHASE_RST;
      end else begin
         pix              <= next_pix;
         rep              <= next_rep;
         line_count_o     <= next_line;
         region_o         <= next_region;
         vertical_phase_o <= next_phase;
      end
   end

   a_field_line_zero: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      field_start |=> (line_count_o == 8'h00 && pix == 9'h000 && rep == 3'h0))
      else $error("line count not restarted at field start");

   a_line_count_step: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (line_start && !field_start && line_count_o != 8'hFF)
      |=> line_count_o == $past(line_count_o) + 8'h01)
      else $error("line count did not advance on line start");

   a_region_highest: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (region_boundary_line_i[31:24] <= line_count_o) |-> act_region == 3'h4)
      else $error("last region not chosen past its boundary");

   a_region_fixed_zero: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (line_count_o == 8'h00 && region_boundary_line_i[7:0] != 8'h00 &&
       region_boundary_line_i[15:8] != 8'h00 && region_boundary_line_i[23:16] != 8'h00 &&
       region_boundary_line_i[31:24] != 8'h00) |=> region_o == 3'h0)
      else $error("region zero not active at line zero");

   a_pointer_direct: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (cur_ptr < 3'h4) |-> cur_pat == pattern_select_i[cur_ptr[1:0]*2 +: 2])
      else $error("direct pointer chose wrong pattern select");

   a_pointer_even_odd: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (cur_ptr == 3'h5) |-> cur_pat == pattern_select_i[(2 + line_count_o[0])*2 +: 2])
      else $error("even odd pointer chose wrong pattern select");

   a_rep_wrap: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (pix_en && pat_active && wrap && !line_start && !field_start)
      |=> (pix == 9'h000 && rep == $past(rep) + 3'h1))
      else $error("pixel counter did not restart after repetition length");

   a_pix_advance: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (pix_en && pat_active && !wrap && pix != 9'h1FF && !line_start && !field_start)
      |=> pix == $past(pix) + 9'h001)
      else $error("pixel counter did not advance");

   a_hold_start: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (rep >= cur_count) |=> vertical_phase_o == $past(cur_start))
      else $error("phase not held at start level after repetitions");

   a_rep_bounded: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (!line_start && !field_start && rep >= cur_count) |=> rep == $past(rep))
      else $error("repetition counter ran past programmed count");

   a_toggle_level: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (pat_active && pix < phase_toggle_a_i[cur_pat*36 +: 9] &&
       pix < phase_toggle_b_i[cur_pat*36 +: 9])
      |=> vertical_phase_o[0] == $past(cur_start[0]))
      else $error("phase left start level before toggle position");

   a_region_follow: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      1'b1 |=> region_o == $past(act_region))
      else $error("region output did not follow active region");

   a_region_range: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      region_o <= 3'h4)
      else $error("region output beyond the last region");

   a_region_zero_below: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (region_boundary_line_i[7:0] > line_count_o && region_boundary_line_i[15:8] > line_count_o &&
       region_boundary_line_i[23:16] > line_count_o && region_boundary_line_i[31:24] > line_count_o)
      |-> act_region == 3'h0)
      else $error("region zero not chosen below all boundaries");

   a_region_one: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (region_boundary_line_i[7:0] <= line_count_o && region_boundary_line_i[15:8] > line_count_o &&
       region_boundary_line_i[23:16] > line_count_o && region_boundary_line_i[31:24] > line_count_o)
      |-> act_region == 3'h1)
      else $error("region one not chosen past its boundary");

   a_region_two: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (region_boundary_line_i[15:8] <= line_count_o && region_boundary_line_i[23:16] > line_count_o &&
       region_boundary_line_i[31:24] > line_count_o) |-> act_region == 3'h2)
      else $error("region two not chosen past its boundary");

   a_region_three: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (region_boundary_line_i[23:16] <= line_count_o && region_boundary_line_i[31:24] > line_count_o)
      |-> act_region == 3'h3)
      else $error("region three not chosen past its boundary");

   a_field_wins: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (field_start && line_start) |=> line_count_o == 8'h00)
      else $error("line edge beat field edge in the same cycle");

   a_line_saturate: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (line_start && !field_start && line_count_o == 8'hFF)
      |=> line_count_o == 8'hFF)
      else $error("line count wrapped past its top value");

   a_line_hold: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (!line_start && !field_start) |=> line_count_o == $past(line_count_o))
      else $error("line count moved without a sync edge");

   a_line_clears_rep: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (line_start && !field_start) |=> (pix == 9'h000 && rep == 3'h0))
      else $error("pixel or repetition count not cleared at line start");

   a_pointer_even_low: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (cur_ptr == 3'h4)
      |-> cur_pat == (line_count_o[0] ? pattern_select_i[3:2] : pattern_select_i[1:0]))
      else $error("lower even odd pointer chose wrong pattern select");

   a_pointer_spare: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (cur_ptr > 3'h5) |-> cur_pat == pattern_select_i[1:0])
      else $error("spare pointer code did not fall back to first select");

   a_pix_saturate: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (pix_en && pat_active && !wrap && pix == 9'h1FF && !line_start && !field_start)
      |=> pix == 9'h1FF)
      else $error("pixel counter wrapped without a repetition length");

   a_pix_hold_done: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (!pat_active && !line_start && !field_start) |=> pix == $past(pix))
      else $error("pixel counter moved after repetitions ended");

   a_zero_count_hold: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (cur_count == 3'h0) |=> vertical_phase_o == $past(cur_start))
      else $error("zero count did not hold the start level");

   a_single_pulse: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (cur_count == 3'h1 && pat_active && pix_en && wrap && !line_start && !field_start)
      |=> (rep == 3'h1 && !pat_active))
      else $error("count of one gave more than one pulse");

   a_toggle_between: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (pat_active && pix >= phase_toggle_a_i[cur_pat*36 +: 9] &&
       pix < phase_toggle_b_i[cur_pat*36 +: 9])
      |=> vertical_phase_o[0] == !$past(cur_start[0]))
      else $error("phase did not leave start level between toggles");

   a_toggle_after: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (pat_active && pix >= phase_toggle_a_i[cur_pat*36 +: 9] &&
       pix >= phase_toggle_b_i[cur_pat*36 +: 9])
      |=> vertical_phase_o[0] == $past(cur_start[0]))
      else $error("phase did not return after second toggle");

   a_toggle_last_phase: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (pat_active && pix < phase_toggle_a_i[cur_pat*36+27 +: 9] &&
       pix < phase_toggle_b_i[cur_pat*36+27 +: 9])
      |=> vertical_phase_o[3] == $past(cur_start[3]))
      else $error("last phase left start level before toggle position");

   a_start_level_p2: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (pat_active && pix < phase_toggle_a_i[cur_pat*36+9 +: 9] &&
       pix < phase_toggle_b_i[cur_pat*36+9 +: 9])
      |=> vertical_phase_o[1] == $past(cur_start[1]))
      else $error("second phase did not start at its start level");

   a_start_from_pat: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      cur_start == phase_start_level_i[cur_pat*4 +: 4])
      else $error("start levels not taken from the chosen pattern");

   a_div_restart: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      pix_en |=> div_cnt == 8'h00)
      else $error("pixel divider did not restart after its step");

   a_level_active: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      pat_active |=> vertical_phase_o == $past(cur_level))
      else $error("active phase level not taken from toggle compare");
endmodule

// File: dv/ccdv_ccd_gates.sv
// behavioural sensor vertical transfer gates, counting gate level changes
`timescale 1ns/10ps
module ccdv_ccd_gates
   import ccdv_pkg::*;
(
   input  wire logic                 clk_sys_i,
   input  wire logic                 reset_n_i,
   input  wire logic [NUM_PHASE-1:0] phase_i,
   output logic      [15:0]          edge_count_o [NUM_PHASE]
);
   logic [NUM_PHASE-1:0] phase_last;
   // each level change moves charge one gate further down the column
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         phase_last <= PHASE_RST;
         for (int k = 0; k < NUM_PHASE; k++) begin
            edge_count_o[k] <= 16'h0000;
         end
      end else begin
         phase_last <= phase_i;
         for (int k = 0; k < NUM_PHASE; k++) begin
            if (phase_i[k] != phase_last[k]) begin
               edge_count_o[k] <= edge_count_o[k] + 16'h0001;
            end
         end
      end
   end
endmodule

// File: dv/ccdv_vtiming_tb.sv
// self-checking bench for the vertical pattern and region generator
`timescale 1ns/10ps
module ccdv_vtiming_tb;
   import ccdv_pkg::*;
   logic                               clk_sys_i;
   logic                               reset_n_i;
   logic                               field_sync;
   logic                               line_sync;
   logic [NUM_PAT*PIX_W-1:0]           len_cfg;
   logic [NUM_PAT*NUM_PHASE-1:0]       start_cfg;
   logic [NUM_PAT*NUM_PHASE*PIX_W-1:0] tog_a;
   logic [NUM_PAT*NUM_PHASE*PIX_W-1:0] tog_b;
   logic [NUM_PAT*REP_W-1:0]           rep_cfg;
   logic [NUM_PAT*SEL_W-1:0]           sel_cfg;
   logic [NUM_REGION*PTR_W-1:0]        ptr_cfg;
   logic [NUM_PROG_BD*LINE_W-1:0]      bd_cfg;
   logic [NUM_PHASE-1:0]               phase;
   logic [REGION_W-1:0]                region;
   logic [LINE_W-1:0]                  line_count;
   logic [15:0]                        gate_edges [NUM_PHASE];
   int                                 n_fail;
   int                                 samples_checked;

   ccdv_vtiming #(.PIX_DIV(1)) DUT (
      .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .field_sync_i(field_sync),
      .line_sync_i(line_sync), .pattern_repeat_length_i(len_cfg),
      .phase_start_level_i(start_cfg), .phase_toggle_a_i(tog_a), .phase_toggle_b_i(tog_b),
      .pattern_repeat_count_i(rep_cfg), .pattern_select_i(sel_cfg),
      .region_pattern_pointer_i(ptr_cfg), .region_boundary_line_i(bd_cfg),
      .vertical_phase_o(phase), .region_o(region), .line_count_o(line_count));

   ccdv_ccd_gates gates (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .phase_i(phase),
      .edge_count_o(gate_edges));

   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      if (n_fail == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   function automatic int exp_region(input int n);
      exp_region = 0;
      for (int i = 0; i < NUM_PROG_BD; i++) begin
         if (bd_cfg[i*8+:8] <= n) exp_region = i + 1;
      end
   endfunction

   function automatic int exp_pat(input int n, input int r);
      int code;
      int s;
      code = ptr_cfg[r*3+:3];
      s = (code < 4) ? code : (code == 4) ? n % 2 : (code == 5) ? 2 + n % 2 : 0;
      exp_pat = sel_cfg[s*2+:2];
   endfunction

   task automatic new_field();
      field_sync <= 1'b0;
      @(posedge clk_sys_i);
      field_sync <= 1'b1;
      repeat (3) @(negedge clk_sys_i);
      check("field_line", line_count, 16'h0000);
      check("field_region", region, 16'h0000);
      @(posedge clk_sys_i);
   endtask

   // one line: high time counted against start level, gate edges from the model
   task automatic run_line(input int n);
      int          r;
      int          p;
      int          cnt;
      int          ones [NUM_PHASE];
      logic [15:0] base [NUM_PHASE];
      r = exp_region(n);
      p = exp_pat(n, r);
      cnt = rep_cfg[p*3+:3];
      ones = '{default: 0};
      line_sync <= 1'b0;
      @(posedge clk_sys_i);
      line_sync <= 1'b1;
      for (int i = 0; i < 95; i++) begin
         @(negedge clk_sys_i);
         if (i == 3) begin
            check("line_count", line_count, 16'(n));
            check("region", region, 16'(r));
         end
         // before the first toggle can reach the model, after the start level switch
         if (i == 2) begin
            base = gate_edges;
         end
         for (int k = 0; k < NUM_PHASE; k++) begin
            if (i >= 3) ones[k] += int'(phase[k] ^ start_cfg[p*4+k]);
         end
      end
      for (int k = 0; k < NUM_PHASE; k++) begin
         check("phase_rest", 16'(phase[k]), 16'(start_cfg[p*4+k]));
         check("phase_high", 16'(ones[k]), 16'(cnt * (p + 1)));
         check("gate_edges", gate_edges[k] - base[k], 16'(2 * cnt));
      end
      @(posedge clk_sys_i);
   endtask

   initial begin
      n_fail = 0;
      samples_checked = 0;
      reset_n_i = 1'b0;
      field_sync = 1'b1;
      line_sync = 1'b1;
      // counts 1, 2, 0 and 7 cover single pulse, dc hold and the top count
      rep_cfg = {3'h7, 3'h0, 3'h2, 3'h1};
      sel_cfg = {2'h0, 2'h1, 2'h2, 2'h3};
      ptr_cfg = {3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
      bd_cfg = {8'h08, 8'h06, 8'h04, 8'h02};
      // pulse width grows with the pattern number
      for (int p = 0; p < NUM_PAT; p++) begin
         len_cfg[p*9+:9] = 9'h00B;
         for (int k = 0; k < NUM_PHASE; k++) begin
            start_cfg[p*4+k] = 1'((p + k) % 2);
            tog_a[(p*4+k)*9+:9] = 9'(k + 3);
            tog_b[(p*4+k)*9+:9] = 9'(k + 4 + p);
         end
      end
      repeat (3) @(negedge clk_sys_i);
      check("reset_outs", 16'({phase, region, line_count}), 16'h0000);
      @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      for (int f = 0; f < 2; f++) begin
         new_field();
         for (int n = 1; n <= 10; n++) begin
            run_line(n);
         end
         ptr_cfg <= {3'h6, 3'h3, 3'h2, 3'h1, 3'h5};
      end
      report_and_stop();
   end

   initial begin
      repeat (10000) @(posedge clk_sys_i);
      n_fail++;
      report_and_stop();
   end
endmodule
